// ==== ssm_pkg.sv ====
`default_nettype none
package ssm_pkg;
	typedef enum logic [2:0] {
		SSM_POWER_ON = 3'h1,
		SSM_MAILBOX_ONLY = 3'h2,
		SSM_INPUTS_LIVE = 3'h4,
		SSM_FULL_RUN = 3'h0,
		SSM_FW_UPDATE = 3'h3
	} ssm_state_e;
	localparam int SSM_IO_WIDTH = 8;
	localparam int SSM_TIME_WIDTH = 32;
	localparam logic [7:0] SSM_SAFE_OUT = 8'h00;
	localparam logic [2:0] SSM_RESET_STATE = 3'h1;
endpackage : ssm_pkg
`default_nettype wire

// ==== ssm_local_time.sv ====
`default_nettype none
module ssm_local_time import ssm_pkg::*; #(
	parameter int TW = SSM_TIME_WIDTH
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic timeEnable,
	input wire logic timeLoad,
	input wire logic [TW-1:0] timeLoadValue,
	output logic [TW-1:0] localTime
);
	logic [TW-1:0] time_reg;
	logic [TW-1:0] time_next;

	// Master datagram overwrites, otherwise free-run while enabled
	assign time_next = timeLoad ? timeLoadValue : (timeEnable ? time_reg + TW'(1) : time_reg);

	// Local clock register
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			time_reg <= '0;
		end else begin
			time_reg <= time_next;
		end
	end
	assign localTime = time_reg;

	tick_follows_a: assert property (@(posedge mclk) disable iff (sys_rst)
		timeLoad |=> localTime == $past(timeLoadValue))
		else $error("local time did not take loaded value");
endmodule : ssm_local_time
`default_nettype wire

// ==== ssm_core.sv ====
`default_nettype none
module ssm_core import ssm_pkg::*; #(
	parameter int IOW = SSM_IO_WIDTH,
	parameter int TW = SSM_TIME_WIDTH
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic reqValid,
	input wire ssm_state_e reqState,
	input wire logic mailboxCfgOk,
	input wire logic processCfgOk,
	input wire logic timeUsed,
	input wire logic timeCfgOk,
	input wire logic watchdogEnable,
	input wire logic [IOW-1:0] masterOutputs,
	input wire logic [IOW-1:0] physInputs,
	input wire logic cycleTick,
	input wire logic timeCapable,
	input wire logic cyclicModeEnable,
	input wire logic refCandidate,
	input wire logic timeLoad,
	input wire logic [TW-1:0] timeLoadValue,
	output ssm_state_e curState,
	output logic ackValid,
	output logic ackError,
	output logic mailboxAllowed,
	output logic fileTransferOnly,
	output logic processAllowed,
	output logic [IOW-1:0] physOutputs,
	output logic [IOW-1:0] inputImage,
	output logic inputImageWrite,
	output logic isRefClock,
	output logic [TW-1:0] localTime
);
	ssm_state_e state_reg;
	ssm_state_e state_next;
	logic [IOW-1:0] out_reg;
	logic [IOW-1:0] out_next;
	logic [IOW-1:0] img_reg;
	logic imgWr_reg;
	logic ack_reg;
	logic err_reg;
	logic checkOk;
	logic legalMove;
	logic enteringSafe;
	logic outputsLive;
	logic accepted;
	logic liveState;
	logic refreshImage;

	// Transition table: forward one step, any move back, update only from power-on
	function automatic logic move_legal(input ssm_state_e fromSt, input ssm_state_e toSt);
		logic ok;
		ok = 1'b0;
		unique case (fromSt)
			SSM_POWER_ON: begin
				ok = toSt == SSM_POWER_ON || toSt == SSM_MAILBOX_ONLY ||
					toSt == SSM_FW_UPDATE;
			end
			SSM_MAILBOX_ONLY: begin
				ok = toSt == SSM_POWER_ON || toSt == SSM_MAILBOX_ONLY ||
					toSt == SSM_INPUTS_LIVE;
			end
			SSM_INPUTS_LIVE: begin
				ok = toSt == SSM_POWER_ON || toSt == SSM_MAILBOX_ONLY ||
					toSt == SSM_INPUTS_LIVE || toSt == SSM_FULL_RUN;
			end
			SSM_FULL_RUN: begin
				ok = toSt == SSM_POWER_ON || toSt == SSM_MAILBOX_ONLY ||
					toSt == SSM_INPUTS_LIVE || toSt == SSM_FULL_RUN;
			end
			SSM_FW_UPDATE: begin
				ok = toSt == SSM_POWER_ON || toSt == SSM_FW_UPDATE;
			end
			default: begin
				ok = toSt == SSM_POWER_ON; // A corrupted state can only fall back
			end
		endcase
		return ok;
	endfunction : move_legal

	// Checks the slave runs before it accepts the moves into mailbox-only and into the safe state
	function automatic logic move_checked(input ssm_state_e fromSt, input ssm_state_e toSt,
		input logic mbxOk, input logic pdOk, input logic tmUsed, input logic tmOk);
		logic ok;
		ok = 1'b1;
		if (fromSt == SSM_POWER_ON && toSt == SSM_MAILBOX_ONLY) begin
			ok = mbxOk;
		end
		if (fromSt == SSM_MAILBOX_ONLY && toSt == SSM_INPUTS_LIVE) begin
			ok = pdOk && (!tmUsed || tmOk);
		end
		return ok;
	endfunction : move_checked

	// States in which process data runs and inputs are refreshed
	function automatic logic is_live(input ssm_state_e st);
		return st == SSM_INPUTS_LIVE || st == SSM_FULL_RUN;
	endfunction : is_live

	// Request decode
	assign legalMove = reqValid && move_legal(state_reg, reqState);
	assign checkOk = move_checked(state_reg, reqState, mailboxCfgOk, processCfgOk,
		timeUsed, timeCfgOk);
	assign accepted = legalMove && checkOk;
	assign liveState = is_live(state_reg);
	assign refreshImage = enteringSafe || (cycleTick && liveState);

	// Next state only on request; failed check holds
	always_comb begin
		state_next = state_reg;
		if (accepted) begin
			state_next = reqState;
		end
	end

	// Input snapshot on safe entry, outputs live only where allowed
	assign enteringSafe = accepted && reqState == SSM_INPUTS_LIVE &&
		state_reg == SSM_MAILBOX_ONLY;
	assign outputsLive = (state_reg == SSM_FULL_RUN) ||
		(state_reg == SSM_INPUTS_LIVE && !watchdogEnable);
	assign out_next = outputsLive ? masterOutputs : SSM_SAFE_OUT;

	// State register
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= ssm_state_e'(SSM_RESET_STATE);
		end else begin
			state_reg <= state_next;
		end
	end

	// Acknowledge pulse one cycle after each request
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			ack_reg <= 1'b0;
			err_reg <= 1'b0;
		end else begin
			ack_reg <= reqValid;
			err_reg <= reqValid && !accepted;
		end
	end

	// Physical outputs, safe unless live
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			out_reg <= SSM_SAFE_OUT;
		end else begin
			out_reg <= out_next;
		end
	end

	// Input image: snapshot on safe entry, then each cycle tick
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			img_reg <= '0;
			imgWr_reg <= 1'b0;
		end else begin
			imgWr_reg <= refreshImage;
			if (refreshImage) begin
				img_reg <= physInputs;
			end
		end
	end

	// Traffic permissions by state
	assign mailboxAllowed = state_reg != SSM_POWER_ON;
	assign fileTransferOnly = state_reg == SSM_FW_UPDATE;
	assign processAllowed = liveState;

	assign curState = state_reg;
	assign ackValid = ack_reg;
	assign ackError = err_reg;
	assign physOutputs = out_reg;
	assign inputImage = img_reg;
	assign inputImageWrite = imgWr_reg;

	// Reference clock role only when configured
	assign isRefClock = timeCapable && cyclicModeEnable && refCandidate;

	// Local clock kept by this slave
	ssm_local_time #(.TW(TW)) uTime (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.timeEnable(timeCapable),
		.timeLoad(timeLoad && timeCapable),
		.timeLoadValue(timeLoadValue),
		.localTime(localTime)
	);

	power_on_quiet_a: assert property (@(posedge mclk) disable iff (sys_rst)
		curState == SSM_POWER_ON |-> !mailboxAllowed && !processAllowed)
		else $error("traffic allowed in power-on state");
	mbx_check_a: assert property (@(posedge mclk) disable iff (sys_rst)
		curState == SSM_POWER_ON && reqValid && reqState == SSM_MAILBOX_ONLY && !mailboxCfgOk
		|=> curState == SSM_POWER_ON && ackError)
		else $error("mailbox-only entered without good mailbox setup");
	mbx_only_a: assert property (@(posedge mclk) disable iff (sys_rst)
		curState == SSM_MAILBOX_ONLY |-> mailboxAllowed && !processAllowed)
		else $error("mailbox-only permissions wrong");
	pd_check_a: assert property (@(posedge mclk) disable iff (sys_rst)
		curState == SSM_MAILBOX_ONLY && reqValid && reqState == SSM_INPUTS_LIVE &&
		(!processCfgOk || (timeUsed && !timeCfgOk)) |=> curState == SSM_MAILBOX_ONLY)
		else $error("safe state entered with bad process setup");
	input_copy_a: assert property (@(posedge mclk) disable iff (sys_rst)
		$changed(curState) && curState == SSM_INPUTS_LIVE && $past(curState) == SSM_MAILBOX_ONLY
		|-> inputImageWrite && inputImage == $past(physInputs))
		else $error("inputs not copied on safe entry");
	safe_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
		curState == SSM_INPUTS_LIVE && watchdogEnable ##1 curState == SSM_INPUTS_LIVE
		|-> physOutputs == SSM_SAFE_OUT)
		else $error("outputs live in safe state with watchdog on");
	wd_off_a: assert property (@(posedge mclk) disable iff (sys_rst)
		curState == SSM_INPUTS_LIVE && !watchdogEnable |=> physOutputs == $past(masterOutputs))
		else $error("outputs not driven with watchdog off");
	run_copy_a: assert property (@(posedge mclk) disable iff (sys_rst)
		curState == SSM_FULL_RUN |=> physOutputs == $past(masterOutputs))
		else $error("full run does not copy outputs");
	fw_entry_a: assert property (@(posedge mclk) disable iff (sys_rst)
		curState != SSM_FW_UPDATE ##1 curState == SSM_FW_UPDATE |-> $past(curState) == SSM_POWER_ON)
		else $error("firmware update entered from wrong state");
	fw_only_a: assert property (@(posedge mclk) disable iff (sys_rst)
		curState == SSM_FW_UPDATE |-> fileTransferOnly && !processAllowed)
		else $error("firmware update permissions wrong");
	no_req_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!reqValid |=> $stable(curState))
		else $error("state changed without request");

	// Every request is answered one cycle later
	ack_pulse_a: assert property (@(posedge mclk) disable iff (sys_rst)
		reqValid |=> ackValid)
		else $error("request not acknowledged");
	// No answer without a request
	ack_quiet_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!reqValid |=> !ackValid && !ackError)
		else $error("acknowledge without request");
	// Refusal only comes with an acknowledge
	err_with_ack_a: assert property (@(posedge mclk) disable iff (sys_rst)
		ackError |-> ackValid)
		else $error("refusal without acknowledge");
	// A refused request leaves the state alone
	refused_stay_a: assert property (@(posedge mclk) disable iff (sys_rst)
		ackError |-> curState == $past(curState))
		else $error("state moved on a refused request");
	// An accepted request lands in the requested state
	accept_move_a: assert property (@(posedge mclk) disable iff (sys_rst)
		ackValid && !ackError |-> curState == $past(reqState))
		else $error("accepted request did not reach its state");
	// Firmware update refused outside power-on and firmware update
	fw_refuse_a: assert property (@(posedge mclk) disable iff (sys_rst)
		curState != SSM_POWER_ON && curState != SSM_FW_UPDATE && reqValid &&
		reqState == SSM_FW_UPDATE |=> ackError)
		else $error("firmware update accepted from wrong state");
	// No process data out of mailbox-only state
	mbx_out_safe_a: assert property (@(posedge mclk) disable iff (sys_rst)
		curState == SSM_MAILBOX_ONLY |=> physOutputs == SSM_SAFE_OUT)
		else $error("outputs driven in mailbox-only state");
	// Safe state carries both traffic kinds
	live_perm_a: assert property (@(posedge mclk) disable iff (sys_rst)
		curState == SSM_INPUTS_LIVE |-> mailboxAllowed && processAllowed)
		else $error("safe state permissions wrong");
	// Full run carries both traffic kinds
	run_perm_a: assert property (@(posedge mclk) disable iff (sys_rst)
		curState == SSM_FULL_RUN |-> mailboxAllowed && processAllowed)
		else $error("full run permissions wrong");
	// Cycle tick refreshes the image in live states
	live_refresh_a: assert property (@(posedge mclk) disable iff (sys_rst)
		cycleTick && (curState == SSM_INPUTS_LIVE || curState == SSM_FULL_RUN)
		|=> inputImageWrite && inputImage == $past(physInputs))
		else $error("inputs not refreshed on cycle tick");
	// No image write without tick or request
	img_quiet_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!cycleTick && !reqValid |=> !inputImageWrite)
		else $error("input image written without cause");
	// Image holds while nothing writes it
	img_stable_a: assert property (@(posedge mclk) disable iff (sys_rst)
		!inputImageWrite |-> $stable(inputImage))
		else $error("input image changed without write");
	// Good process setup lets the safe state in
	pd_ok_move_a: assert property (@(posedge mclk) disable iff (sys_rst)
		curState == SSM_MAILBOX_ONLY && reqValid && reqState == SSM_INPUTS_LIVE &&
		processCfgOk && (!timeUsed || timeCfgOk) |=> curState == SSM_INPUTS_LIVE)
		else $error("safe state refused with good setup");
	// Good mailbox setup lets mailbox-only in
	mbx_ok_move_a: assert property (@(posedge mclk) disable iff (sys_rst)
		curState == SSM_POWER_ON && reqValid && reqState == SSM_MAILBOX_ONLY &&
		mailboxCfgOk |=> curState == SSM_MAILBOX_ONLY && !ackError)
		else $error("mailbox-only refused with good setup");
	// Full run only reached from the safe state
	run_entry_a: assert property (@(posedge mclk) disable iff (sys_rst)
		curState != SSM_FULL_RUN ##1 curState == SSM_FULL_RUN |->
		$past(curState) == SSM_INPUTS_LIVE)
		else $error("full run entered from wrong state");
	// Leaving power-on goes one step only
	po_exit_a: assert property (@(posedge mclk) disable iff (sys_rst)
		curState == SSM_POWER_ON ##1 curState != SSM_POWER_ON |->
		curState == SSM_MAILBOX_ONLY || curState == SSM_FW_UPDATE)
		else $error("power-on left to wrong state");
	// State register holds only known codes
	state_legal_a: assert property (@(posedge mclk) disable iff (sys_rst)
		curState inside {SSM_POWER_ON, SSM_MAILBOX_ONLY, SSM_INPUTS_LIVE, SSM_FULL_RUN,
		SSM_FW_UPDATE})
		else $error("state register holds unknown code");
	// File-transfer flag only in firmware update
	ft_flag_a: assert property (@(posedge mclk) disable iff (sys_rst)
		fileTransferOnly |-> curState == SSM_FW_UPDATE)
		else $error("file-transfer flag outside firmware update");
	// Reference role needs both configuration bits and time capability
	ref_role_a: assert property (@(posedge mclk) disable iff (sys_rst)
		isRefClock |-> cyclicModeEnable && refCandidate && timeCapable)
		else $error("reference role without configuration");
	// Local clock counts while enabled and not loaded
	time_run_a: assert property (@(posedge mclk) disable iff (sys_rst)
		timeCapable && !timeLoad |=> localTime == $past(localTime) + TW'(1))
		else $error("local clock did not advance");
endmodule : ssm_core
`default_nettype wire

// ==== ssm_master_model.sv ====
`default_nettype none
module ssm_master_model import ssm_pkg::*; (
	input wire logic mclk,
	output logic reqValid,
	output ssm_state_e reqState
);
	timeunit 1ns;
	timeprecision 1ns;
	// One request held across one sampling edge, then released
	task automatic request(input ssm_state_e st);
		@(negedge mclk);
		reqState = st; // configuration levels are set before the request
		reqValid = 1'b1;
		@(negedge mclk);
		reqValid = 1'b0;
		reqState = ssm_state_e'(~st); // Released lines do not keep the last value
	endtask : request
	// Idle until the first request
	initial begin
		reqValid = 1'b0;
		reqState = SSM_POWER_ON;
	end
endmodule : ssm_master_model
`default_nettype wire

// ==== test_slave_state_machine.sv ====
`default_nettype none
module test_slave_state_machine import ssm_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'b0, sys_rst = 1'b1, reqValid, mbOk = 1'b0, pcOk = 1'b0, wdEn = 1'b1, tick = 1'b0;
	logic tCap = 1'b0, cyc = 1'b0, refC = 1'b0, tLoad = 1'b0, ackValid, ackError, mbAl, ftOnly;
	logic prAl, imgWr, isRef, tUsed = 1'b0, tOk = 1'b0;
	logic [7:0] mOut = 8'h00, pIn = 8'h00, physOutputs, inputImage;
	logic [31:0] localTime;
	ssm_state_e reqState, curState;
	int mismatches = 0, n_tests = 0;
	// Clock at 20 MHz
	always #25 mclk = ~mclk;
	ssm_master_model master (.mclk(mclk), .reqValid(reqValid), .reqState(reqState));
	ssm_core uut (.mclk(mclk), .sys_rst(sys_rst), .reqValid(reqValid), .reqState(reqState),
		.mailboxCfgOk(mbOk), .processCfgOk(pcOk), .timeUsed(tUsed), .timeCfgOk(tOk),
		.watchdogEnable(wdEn), .masterOutputs(mOut), .physInputs(pIn), .cycleTick(tick),
		.timeCapable(tCap), .cyclicModeEnable(cyc), .refCandidate(refC), .timeLoad(tLoad),
		.timeLoadValue(32'h0000_0100), .curState(curState), .ackValid(ackValid),
		.ackError(ackError), .mailboxAllowed(mbAl), .fileTransferOnly(ftOnly),
		.processAllowed(prAl), .physOutputs(physOutputs), .inputImage(inputImage),
		.inputImageWrite(imgWr), .isRefClock(isRef), .localTime(localTime));
	// Compare one value
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Request a state and judge the acknowledge
	task automatic req(input ssm_state_e st, input logic err, input ssm_state_e expSt);
		master.request(st);
		chk({ackValid, ackError}, {1'b1, err});
		chk(curState, expSt);
	endtask : req
	// Summary and verdict
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	// Power-on, refusals and firmware update path
	task automatic t_power_on();
		chk({curState, mbAl, prAl}, {SSM_POWER_ON, 2'b00});
		req(SSM_MAILBOX_ONLY, 1'b1, SSM_POWER_ON);
		req(SSM_FW_UPDATE, 1'b0, SSM_FW_UPDATE);
		chk({ftOnly, prAl}, 2'b10);
		req(SSM_POWER_ON, 1'b0, SSM_POWER_ON);
	endtask : t_power_on
	// Normal startup through to full run
	task automatic t_startup();
		mbOk = 1'b1;
		req(SSM_MAILBOX_ONLY, 1'b0, SSM_MAILBOX_ONLY);
		chk({mbAl, prAl}, 2'b10);
		req(SSM_FW_UPDATE, 1'b1, SSM_MAILBOX_ONLY);
		req(SSM_INPUTS_LIVE, 1'b1, SSM_MAILBOX_ONLY);
		pcOk = 1'b1;
		tUsed = 1'b1;
		req(SSM_INPUTS_LIVE, 1'b1, SSM_MAILBOX_ONLY);
		tOk = 1'b1;
		pIn = 8'hA5;
		mOut = 8'h3C;
		req(SSM_INPUTS_LIVE, 1'b0, SSM_INPUTS_LIVE);
		chk({inputImage, imgWr}, {8'hA5, 1'b1});
		chk({mbAl, prAl, physOutputs}, {2'b11, SSM_SAFE_OUT});
		pIn = 8'h5A;
		tick = 1'b1;
		@(negedge mclk) tick = 1'b0;
		chk(inputImage, 8'h5A);
		wdEn = 1'b0;
		repeat (2) @(negedge mclk);
		chk(physOutputs, 8'h3C);
		wdEn = 1'b1;
		mOut = 8'hC3;
		req(SSM_FULL_RUN, 1'b0, SSM_FULL_RUN);
		chk(physOutputs, SSM_SAFE_OUT);
		@(negedge mclk);
		chk({mbAl, prAl, physOutputs}, {2'b11, 8'hC3});
	endtask : t_startup
	// Local time load and reference role
	task automatic t_time();
		tCap = 1'b1;
		refC = 1'b1;
		tLoad = 1'b1;
		@(negedge mclk) tLoad = 1'b0;
		chk(localTime, 32'h0000_0100);
		chk(isRef, 1'b0);
		cyc = 1'b1;
		@(negedge mclk);
		chk(isRef, 1'b1);
	endtask : t_time
	// Main sequence
	initial begin
		repeat (12) @(negedge mclk);
		sys_rst = 1'b0;
		t_power_on();
		t_startup();
		t_time();
		give_verdict();
	end
	// Hang limit
	initial begin
		repeat (5000) @(posedge mclk);
		mismatches++;
		give_verdict();
	end
endmodule : test_slave_state_machine
`default_nettype wire
